/* File: gpm_output_mux.sv */
// What this block does
// RL1: source field bits 4:2 picks rx port 0-3, status, or tx port
// RL2: select field bits 7:5 is decoded according to current source
// RL3: rx source, select 000-011 drives forwarded remote gpio 0-3
// RL4: rx source, select 100 gives lock, 101 gives pass
// RL5: rx source, select 110 gives frame valid, 111 line valid
// RL6: status source, select 000 drives the value bit
// RL7: status source, 001 is or of enabled locks, 010 the and
// RL8: status source, 011 is and of enabled port pass
// RL9: status source, 100 drives frame sync; 101-111 reserved
// RL10: tx source, 000 and of selected pass, 001 the or
// RL11: tx source, 010 frame being sent, 011 line being sent
// RL12: tx source, 100 synchronized, 101 interrupt, 110-111 reserved
// RL13: bit 1 holds the software level for the value output
// RL14: bit 0 enables the driver; all fields reset to zero
// RL15: pin 6 has its own identical independent control register
// RL16: reserved codes drive low on an enabled pin
// RL17: enable bit 0 leaves the pin undriven
//
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "gpm_regs.svh"

module gpm_output_mux
    import gpm_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [9:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic [3:0]  rxGpio0,
    input  wire logic [3:0]  rxGpio1,
    input  wire logic [3:0]  rxGpio2,
    input  wire logic [3:0]  rxGpio3,
    input  wire logic [3:0]  rxLock,
    input  wire logic [3:0]  rxPass,
    input  wire logic [3:0]  rxFrameValid,
    input  wire logic [3:0]  rxLineValid,
    input  wire logic        frameSyncSignal,
    input  wire logic [1:0]  txFrame,
    input  wire logic [1:0]  txLine,
    input  wire logic [1:0]  txSynced,
    input  wire logic [1:0]  txIrq,
    input  wire logic        pin5In,
    input  wire logic        pin6In,
    output logic             pin5Out,
    output logic             pin5Oe,
    output logic             pin6Out,
    output logic             pin6Oe
);

    ////////////////////////////////////////////////////////////////////////
    // input synchronisation

    localparam int SYNC_W = 43;

    logic [SYNC_W-1:0] rawIn;
    logic [SYNC_W-1:0] syncIn;

    assign rawIn = {rxGpio0, rxGpio1, rxGpio2, rxGpio3, rxLock, rxPass,
                    rxFrameValid, rxLineValid, frameSyncSignal,
                    txFrame, txLine, txSynced, txIrq, pin5In, pin6In};

    // link status arrives from other domains
    gpm_sync2 #(
        .WIDTH (SYNC_W)
    ) u_sync (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .asyncIn (rawIn),
        .syncOut (syncIn)
    );

    logic [3:0] sGpio0;
    logic [3:0] sGpio1;
    logic [3:0] sGpio2;
    logic [3:0] sGpio3;
    logic [3:0] sLock;
    logic [3:0] sPass;
    logic [3:0] sFv;
    logic [3:0] sLv;
    logic       sFsync;
    logic [1:0] sTxFrame;
    logic [1:0] sTxLine;
    logic [1:0] sTxSynced;
    logic [1:0] sTxIrq;
    logic       sPin5;
    logic       sPin6;

    assign {sGpio0, sGpio1, sGpio2, sGpio3, sLock, sPass, sFv, sLv,
            sFsync, sTxFrame, sTxLine, sTxSynced, sTxIrq,
            sPin5, sPin6} = syncIn;

    ////////////////////////////////////////////////////////////////////////
    // wishbone slave

    gpm_bus_state_t busState_ff;
    gpm_bus_state_t nxt_busState;
    logic           busReq;
    logic           busWr;
    logic [31:0]    nxt_rdData;
    logic [31:0]    rdData_ff;

    assign busReq = wb_cyc_i && wb_stb_i;

    always_comb begin
        nxt_busState = busState_ff;
        case (busState_ff)
            GPM_BUS_IDLE: if (busReq) nxt_busState = GPM_BUS_ACK;
            GPM_BUS_ACK:  nxt_busState = GPM_BUS_IDLE;
            default:      nxt_busState = GPM_BUS_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            busState_ff <= GPM_BUS_IDLE;
        end else begin
            busState_ff <= nxt_busState;
        end
    end

    // one wait state gives registered read data; ack drops after one cycle
    assign wb_ack_o = (busState_ff == GPM_BUS_ACK) && busReq;
    // write commits at the acking edge, low lane only
    assign busWr = wb_ack_o && wb_we_i && wb_sel_i[0];

    ////////////////////////////////////////////////////////////////////////
    // control registers

    logic [7:0] pin5Ctl_ff;
    logic [7:0] pin6Ctl_ff;
    logic [7:0] portCfg_ff;

    // RL14: fields reset to zero
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin5Ctl_ff <= `GPM_CTL_RESET;
        end else if (busWr && wb_adr_i == `GPM_ADDR_PIN5_CTL) begin
            // RL13: value bit stored
            pin5Ctl_ff <= wb_dat_i[7:0];
        end
    end

    // RL15: pin 6 independent register
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin6Ctl_ff <= `GPM_CTL_RESET;
        end else if (busWr && wb_adr_i == `GPM_ADDR_PIN6_CTL) begin
            pin6Ctl_ff <= wb_dat_i[7:0];
        end
    end

    // low nibble enables rx ports, high nibble picks rx ports for tx 0;
    // tx 1 always takes all four, which saves a second mask register
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            portCfg_ff <= `GPM_PORT_CFG_RESET;
        end else if (busWr && wb_adr_i == `GPM_ADDR_PORT_CFG) begin
            portCfg_ff <= wb_dat_i[7:0];
        end
    end

    always_comb begin
        nxt_rdData = 32'h0000_0000;
        case (wb_adr_i)
            `GPM_ADDR_PIN5_CTL:   nxt_rdData[7:0] = pin5Ctl_ff;
            `GPM_ADDR_PIN6_CTL:   nxt_rdData[7:0] = pin6Ctl_ff;
            `GPM_ADDR_INPUT_STAT: nxt_rdData[1:0] = {sPin6, sPin5};
            `GPM_ADDR_PORT_CFG:   nxt_rdData[7:0] = portCfg_ff;
            default:              nxt_rdData = 32'h0000_0000;
        endcase
    end

    // unmapped addresses ack with zero data
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdData_ff <= 32'h0000_0000;
        end else begin
            rdData_ff <= nxt_rdData;
        end
    end

    assign wb_dat_o = rdData_ff;

    ////////////////////////////////////////////////////////////////////////
    // pin muxes

    logic [3:0] txSel1;

    assign txSel1 = 4'hF;

    // RL1: pin 5 output mux
    gpm_pin_mux u_pin5 (
        .ref_clk         (ref_clk),
        .sys_rst         (sys_rst),
        .ctlReg          (pin5Ctl_ff),
        .rxGpio0         (sGpio0),
        .rxGpio1         (sGpio1),
        .rxGpio2         (sGpio2),
        .rxGpio3         (sGpio3),
        .rxLock          (sLock),
        .rxPass          (sPass),
        .rxFrameValid    (sFv),
        .rxLineValid     (sLv),
        .rxEnabled       (portCfg_ff[3:0]),
        .frameSyncSignal (sFsync),
        .txPortSel0      (portCfg_ff[7:4]),
        .txPortSel1      (txSel1),
        .txFrame         (sTxFrame),
        .txLine          (sTxLine),
        .txSynced        (sTxSynced),
        .txIrq           (sTxIrq),
        .pinOut          (pin5Out),
        .pinOe           (pin5Oe)
    );

    // RL15: pin 6 output mux
    gpm_pin_mux u_pin6 (
        .ref_clk         (ref_clk),
        .sys_rst         (sys_rst),
        .ctlReg          (pin6Ctl_ff),
        .rxGpio0         (sGpio0),
        .rxGpio1         (sGpio1),
        .rxGpio2         (sGpio2),
        .rxGpio3         (sGpio3),
        .rxLock          (sLock),
        .rxPass          (sPass),
        .rxFrameValid    (sFv),
        .rxLineValid     (sLv),
        .rxEnabled       (portCfg_ff[3:0]),
        .frameSyncSignal (sFsync),
        .txPortSel0      (portCfg_ff[7:4]),
        .txPortSel1      (txSel1),
        .txFrame         (sTxFrame),
        .txLine          (sTxLine),
        .txSynced        (sTxSynced),
        .txIrq           (sTxIrq),
        .pinOut          (pin6Out),
        .pinOe           (pin6Oe)
    );

endmodule

/* File: gpm_regs.svh */
`ifndef GPM_REGS_SVH
`define GPM_REGS_SVH

// register indices; byte address is four times the index
`define GPM_IDX_PIN5_CTL      8'h15
`define GPM_IDX_PIN6_CTL      8'h16
`define GPM_ADDR_PIN5_CTL     10'h054
`define GPM_ADDR_PIN6_CTL     10'h058
`define GPM_ADDR_INPUT_STAT   10'h060
`define GPM_ADDR_PORT_CFG     10'h064

// field positions of a pin control register
`define GPM_SEL_MSB           7
`define GPM_SEL_LSB           5
`define GPM_SRC_MSB           4
`define GPM_SRC_LSB           2
`define GPM_VAL_BIT           1
`define GPM_EN_BIT            0

`define GPM_CTL_RESET         8'h00
`define GPM_PORT_CFG_RESET    8'h00

`endif

/* File: gpm_pkg.sv */
package gpm_pkg;

    typedef enum logic [2:0] {
        GPM_SRC_RX0    = 3'h0,
        GPM_SRC_RX1    = 3'h1,
        GPM_SRC_RX2    = 3'h2,
        GPM_SRC_RX3    = 3'h3,
        GPM_SRC_STATUS = 3'h4,
        GPM_SRC_RSVD   = 3'h5,
        GPM_SRC_TX0    = 3'h6,
        GPM_SRC_TX1    = 3'h7
    } gpm_src_t;

    typedef enum logic [2:0] {
        GPM_RX_GPIO0 = 3'h0,
        GPM_RX_GPIO1 = 3'h1,
        GPM_RX_GPIO2 = 3'h2,
        GPM_RX_GPIO3 = 3'h3,
        GPM_RX_LOCK  = 3'h4,
        GPM_RX_PASS  = 3'h5,
        GPM_RX_FV    = 3'h6,
        GPM_RX_LV    = 3'h7
    } gpm_rx_sel_t;

    typedef enum logic [2:0] {
        GPM_ST_VALUE    = 3'h0,
        GPM_ST_LOCK_OR  = 3'h1,
        GPM_ST_LOCK_AND = 3'h2,
        GPM_ST_PASS_AND = 3'h3,
        GPM_ST_FSYNC    = 3'h4
    } gpm_st_sel_t;

    typedef enum logic [2:0] {
        GPM_TX_PASS_AND = 3'h0,
        GPM_TX_PASS_OR  = 3'h1,
        GPM_TX_FRAME    = 3'h2,
        GPM_TX_LINE     = 3'h3,
        GPM_TX_SYNCED   = 3'h4,
        GPM_TX_IRQ      = 3'h5
    } gpm_tx_sel_t;

    // one-hot bus slave states
    typedef enum logic [1:0] {
        GPM_BUS_IDLE = 2'b01,
        GPM_BUS_ACK  = 2'b10
    } gpm_bus_state_t;

endpackage

/* File: gpm_sync2.sv */
`timescale 1ns/1ps

module gpm_sync2 #(
    parameter int WIDTH = 1
) (
    input  wire logic             ref_clk,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] stage1_ff;
    logic [WIDTH-1:0] stage2_ff;

    // first stage feeds only the second
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            stage1_ff <= '0;
            stage2_ff <= '0;
        end else begin
            stage1_ff <= asyncIn;
            stage2_ff <= stage1_ff;
        end
    end

    assign syncOut = stage2_ff;

endmodule

/* File: gpm_pin_mux.sv */
`timescale 1ns/1ps
`include "gpm_regs.svh"

module gpm_pin_mux
    import gpm_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    input  wire logic [7:0] ctlReg,
    input  wire logic [3:0] rxGpio0,
    input  wire logic [3:0] rxGpio1,
    input  wire logic [3:0] rxGpio2,
    input  wire logic [3:0] rxGpio3,
    input  wire logic [3:0] rxLock,
    input  wire logic [3:0] rxPass,
    input  wire logic [3:0] rxFrameValid,
    input  wire logic [3:0] rxLineValid,
    input  wire logic [3:0] rxEnabled,
    input  wire logic       frameSyncSignal,
    input  wire logic [3:0] txPortSel0,
    input  wire logic [3:0] txPortSel1,
    input  wire logic [1:0] txFrame,
    input  wire logic [1:0] txLine,
    input  wire logic [1:0] txSynced,
    input  wire logic [1:0] txIrq,
    output logic            pinOut,
    output logic            pinOe
);

    logic [2:0] srcCode;
    logic [2:0] selCode;
    logic [1:0] rxIdx;
    logic       txIdx;
    logic [3:0] txSel;
    logic [3:0] rxEnLock;
    logic [3:0] rxEnPass;
    logic [3:0] txPassSel;
    logic       nxt_pinOut;
    logic       pinOut_ff;
    logic       pinOe_ff;

    assign srcCode = ctlReg[`GPM_SRC_MSB:`GPM_SRC_LSB];
    assign selCode = ctlReg[`GPM_SEL_MSB:`GPM_SEL_LSB];
    assign rxIdx   = srcCode[1:0];
    assign txIdx   = srcCode[0];
    assign txSel   = txIdx ? txPortSel1 : txPortSel0;
    // disabled ports count as neutral for and, absent for or
    assign rxEnLock  = rxLock & rxEnabled;
    assign rxEnPass  = rxPass | ~rxEnabled;
    assign txPassSel = rxPass | ~txSel;

    always_comb begin
        nxt_pinOut = 1'b0;
        case (srcCode)
            // RL1: rx port source
            GPM_SRC_RX0, GPM_SRC_RX1, GPM_SRC_RX2, GPM_SRC_RX3: begin
                case (selCode)
                    // RL3: forwarded remote gpio
                    GPM_RX_GPIO0: nxt_pinOut = rxGpio0[rxIdx];
                    GPM_RX_GPIO1: nxt_pinOut = rxGpio1[rxIdx];
                    GPM_RX_GPIO2: nxt_pinOut = rxGpio2[rxIdx];
                    GPM_RX_GPIO3: nxt_pinOut = rxGpio3[rxIdx];
                    // RL4: lock and pass
                    GPM_RX_LOCK:  nxt_pinOut = rxLock[rxIdx];
                    GPM_RX_PASS:  nxt_pinOut = rxPass[rxIdx];
                    // RL5: frame and line valid
                    GPM_RX_FV:    nxt_pinOut = rxFrameValid[rxIdx];
                    GPM_RX_LV:    nxt_pinOut = rxLineValid[rxIdx];
                    default:      nxt_pinOut = 1'b0;
                endcase
            end
            // RL1: device status source
            GPM_SRC_STATUS: begin
                // RL2: select by source
                case (selCode)
                    // RL6: register value
                    GPM_ST_VALUE:    nxt_pinOut = ctlReg[`GPM_VAL_BIT];
                    // RL7: lock or / and
                    GPM_ST_LOCK_OR:  nxt_pinOut = |rxEnLock;
                    GPM_ST_LOCK_AND: nxt_pinOut = (|rxEnabled) &&
                        ((rxLock & rxEnabled) == rxEnabled);
                    // RL8: pass and
                    GPM_ST_PASS_AND: nxt_pinOut = (|rxEnabled) &&
                        (&rxEnPass);
                    // RL9: frame sync
                    GPM_ST_FSYNC:    nxt_pinOut = frameSyncSignal;
                    // RL16: reserved drives low
                    default:         nxt_pinOut = 1'b0;
                endcase
            end
            // RL1: csi-2 transmit sources
            GPM_SRC_TX0, GPM_SRC_TX1: begin
                case (selCode)
                    // RL10: pass and / or
                    GPM_TX_PASS_AND: nxt_pinOut = (|txSel) && (&txPassSel);
                    GPM_TX_PASS_OR:  nxt_pinOut = |(rxPass & txSel);
                    // RL11: frame and line
                    GPM_TX_FRAME:    nxt_pinOut = txFrame[txIdx];
                    GPM_TX_LINE:     nxt_pinOut = txLine[txIdx];
                    // RL12: synced and interrupt
                    GPM_TX_SYNCED:   nxt_pinOut = txSynced[txIdx];
                    GPM_TX_IRQ:      nxt_pinOut = txIrq[txIdx];
                    // RL16: reserved drives low
                    default:         nxt_pinOut = 1'b0;
                endcase
            end
            // RL16: reserved source low
            default: nxt_pinOut = 1'b0;
        endcase
    end

    // registered so the pin never glitches on mux changes
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pinOut_ff <= 1'b0;
            pinOe_ff  <= 1'b0;
        end else begin
            // RL17: disabled pin undriven
            pinOut_ff <= nxt_pinOut & ctlReg[`GPM_EN_BIT];
            // RL14: output enable
            pinOe_ff  <= ctlReg[`GPM_EN_BIT];
        end
    end

    assign pinOut = pinOut_ff;
    assign pinOe  = pinOe_ff;

endmodule

/* File: gpm_output_mux_sva.sv */
`timescale 1ns/1ps
module gpm_output_mux_sva (
    input wire logic        ref_clk,
    input wire logic        sys_rst,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [9:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        pin5Out,
    input wire logic        pin5Oe,
    input wire logic        pin6Out,
    input wire logic        pin6Oe
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////////////
    AST_ACK_ONE: assert property (
        $rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    AST_ACK_PULSE: assert property (
        wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    AST_ACK_REQ: assert property (
        wb_ack_o |-> wb_cyc_i && wb_stb_i) else $error("ack without request");
    AST_DAT_HIGH: assert property (
        wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper data set");
    AST_P5_OFF: assert property (
        !pin5Oe |-> !pin5Out) else $error("pin5 level while undriven");
    AST_P6_OFF: assert property (
        !pin6Oe |-> !pin6Out) else $error("pin6 level while undriven");
    // enable only moves through a write to its own register
    AST_P5_OE_SRC: assert property (
        $changed(pin5Oe) |->
        $past(wb_ack_o && wb_we_i && wb_adr_i == 10'h054, 2))
        else $error("pin5 enable moved without write");
    AST_P6_OE_SRC: assert property (
        $changed(pin6Oe) |->
        $past(wb_ack_o && wb_we_i && wb_adr_i == 10'h058, 2))
        else $error("pin6 enable moved without write");
    AST_RST_CLEAR: assert property (
        $fell(sys_rst) |-> !pin5Oe && !pin6Oe && !wb_ack_o)
        else $error("outputs not cleared by reset");
    CV_WRITE: cover property (wb_ack_o && wb_we_i);
    CV_P5_ON: cover property ($rose(pin5Oe));
    CV_P6_HIGH: cover property (pin6Oe && pin6Out);
endmodule

bind gpm_output_mux gpm_output_mux_sva u_sva (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pin5Out(pin5Out),
    .pin5Oe(pin5Oe), .pin6Out(pin6Out), .pin6Oe(pin6Oe));

/* File: gpm_pin_probe.sv */
`timescale 1ns/1ps
module gpm_pin_probe (
    input  wire logic       ref_clk,
    input  wire logic       pin5Out,
    input  wire logic       pin5Oe,
    input  wire logic       pin6Out,
    input  wire logic       pin6Oe,
    input  wire logic       smpReq,
    output logic            pin5In,
    output logic            pin6In,
    output logic            smpVld,
    output logic [3:0]      smpData
);
    logic toggle = 1'b0;
    always @(posedge ref_clk) toggle <= ~toggle;
    // undriven wire floats
    // no pull on these pins, so a floating wire shows a moving pattern
    assign pin5In = pin5Oe ? pin5Out : toggle;
    assign pin6In = pin6Oe ? pin6Out : ~toggle;
    always @(posedge ref_clk) begin
        smpVld <= smpReq;
        smpData <= {pin6Oe, pin6Out, pin5Oe, pin5Out};
    end
endmodule

/* File: gpm_output_mux_tb.sv */
`timescale 1ns/1ps
module gpm_output_mux_tb;
    import gpm_pkg::*;
    typedef struct packed {logic isPin; logic [31:0] val;} gpm_exp_t;
    logic        ref_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, smpReq = 1'b0;
    logic [9:0]  adr = 10'h000;
    logic [31:0] datW = 32'h0;
    logic [47:0] stim = 48'h0;
    logic [31:0] datR;
    logic        ack, p5In, p6In, p5Out, p5Oe, p6Out, p6Oe, smpVld;
    logic [3:0]  smpData;
    logic [15:0] lfsr = 16'hC0B2;
    gpm_exp_t    expQ[$];
    gpm_exp_t    expHead;
    int          err_total = 0;
    int          cmp_count = 0;
    always #25 ref_clk = ~ref_clk;
    gpm_output_mux u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(datW), .wb_dat_o(datR), .wb_ack_o(ack),
        .rxGpio0(stim[3:0]), .rxGpio1(stim[7:4]), .rxGpio2(stim[11:8]),
        .rxGpio3(stim[15:12]), .rxLock(stim[19:16]), .rxPass(stim[23:20]),
        .rxFrameValid(stim[27:24]), .rxLineValid(stim[31:28]),
        .frameSyncSignal(stim[32]), .txFrame(stim[34:33]),
        .txLine(stim[36:35]), .txSynced(stim[38:37]), .txIrq(stim[40:39]),
        .pin5In(p5In), .pin6In(p6In), .pin5Out(p5Out), .pin5Oe(p5Oe),
        .pin6Out(p6Out), .pin6Oe(p6Oe));
    gpm_pin_probe u_probe (.ref_clk(ref_clk), .pin5Out(p5Out),
        .pin5Oe(p5Oe), .pin6Out(p6Out), .pin6Oe(p6Oe), .smpReq(smpReq),
        .pin5In(p5In), .pin6In(p6In), .smpVld(smpVld), .smpData(smpData));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // expected {enable, level} of one pin
    function automatic logic [1:0] exp_pin(input logic [7:0] c,
        input logic [7:0] cfg, input logic [47:0] s);
        logic [3:0] m;
        logic       v;
        m = c[2] ? 4'hF : cfg[7:4];
        v = 1'b0;
        if (!c[4]) v = s[{c[7:5], c[3:2]}];
        else if (c[4:2] == 3'h4) begin
            case (c[7:5])
                3'h0: v = c[1];
                3'h1: v = |(s[19:16] & cfg[3:0]);
                3'h2: v = (cfg[3:0] != 0) && &(s[19:16] | ~cfg[3:0]);
                3'h3: v = (cfg[3:0] != 0) && &(s[23:20] | ~cfg[3:0]);
                3'h4: v = s[32];
                default: v = 1'b0;
            endcase
        end else if (c[3]) begin
            case (c[7:5])
                3'h0: v = (m != 0) && &(s[23:20] | ~m);
                3'h1: v = |(s[23:20] & m);
                3'h6, 3'h7: v = 1'b0;
                default: v = s[33 + 2 * (c[7:5] - 2) + c[2]];
            endcase
        end
        return c[0] ? {1'b1, v} : 2'b00;
    endfunction
    task automatic wb_xfer(input logic [9:0] a, input logic w,
        input logic [31:0] d);
        @(posedge ref_clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; datW <= d;
        // no fixed wait assumed; only the watchdog ends a hung wait
        do begin
            @(posedge ref_clk);
        end while (ack !== 1'b1);
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask
    task automatic rd(input logic [9:0] a, input logic [31:0] e);
        expQ.push_back({1'b0, e});
        wb_xfer(a, 1'b0, 32'h0);
    endtask
    task automatic smp(input logic [3:0] e);
        expQ.push_back({1'b1, 28'h0, e});
        @(posedge ref_clk);
        smpReq <= 1'b1;
        @(posedge ref_clk);
        smpReq <= 1'b0;
    endtask
    task automatic finish_test;
        $display("errors %0d compares %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    always @(posedge ref_clk) begin
        if ((ack === 1'b1 && we === 1'b0) || smpVld === 1'b1) begin
            if (expQ.size() == 0) begin
                err_total++;
                $display("CHECK FAILED queue expected entry seen none");
            end else begin
                expHead = expQ.pop_front();
                cmp_count++;
                if (expHead.isPin ? smpData !== expHead.val[3:0]
                                  : datR !== expHead.val) begin
                    err_total++;
                    $display("CHECK FAILED %s expected %h seen %h",
                        expHead.isPin ? "pins" : "rdata", expHead.val,
                        expHead.isPin ? {28'h0, smpData} : datR);
                end
            end
        end
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_total++;
        $display("CHECK FAILED run expected end seen hang");
        finish_test();
    end
    initial begin
        logic [7:0]  c5, c6, cfg;
        logic [47:0] sv;
        logic [1:0]  e5, e6;
        sv = 48'h0;
        repeat (16) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd(10'h054, 32'h0);
        rd(10'h058, 32'h0);
        rd(10'h3FC, 32'h0);
        smp(4'h0);
        // every source and select code on pin 5, its disabled half first; pin 6 takes random codes
        for (int i = 0; i < 128; i++) begin
            repeat (3) begin
                lfsr = lfsr_next(lfsr);
                sv = {sv[31:0], lfsr};
            end
            stim <= sv;
            cfg = lfsr[7:0];
            c6 = lfsr[15:8];
            c5 = {i[5:0], lfsr[3], i[6]};
            wb_xfer(10'h064, 1'b1, {24'h0, cfg});
            wb_xfer(10'h054, 1'b1, {24'h0, c5});
            wb_xfer(10'h058, 1'b1, {24'h0, c6});
            repeat (4) @(posedge ref_clk);
            e5 = exp_pin(c5, cfg, sv);
            e6 = exp_pin(c6, cfg, sv);
            smp({e6, e5});
            rd(10'h054, {24'h0, c5});
            rd(10'h064, {24'h0, cfg});
            // a released pin floats, so readback is checked only when driven
            if (c5[0] && c6[0])
                rd(10'h060, {30'h0, e6[0], e5[0]});
        end
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd(10'h058, 32'h0);
        smp(4'h0);
        repeat (4) @(posedge ref_clk);
        finish_test();
    end
endmodule
